// ==== include/rfbo_pkg.sv ====
// Purpose: Shared constants and types for the reset-flag and brown-out block
// Assumes: 8-bit special-function-register bus, one system clock
// Notes: Threshold field is 3 bits wide at [6:4]; all three bits pick the level
package rfbo_pkg;
  localparam logic [7:0] ADDR_AUX = 8'ha2;
  localparam logic [7:0] ADDR_BOD = 8'ha3;
  // aux_reset_flags_ctrl fields
  localparam int AUX_SOFT = 7;
  localparam int AUX_PIN = 6;
  localparam int AUX_FAULT = 5;
  localparam int AUX_USER = 3;
  localparam int AUX_SWAP = 2;
  localparam int AUX_RSVD = 1;
  localparam int AUX_DPS = 0;
  // brownout_control fields
  localparam int BOD_EN = 7;
  localparam int BOD_LVL_HI = 6;
  localparam int BOD_LVL_LO = 4;
  localparam int BOD_IRQF = 3;
  localparam int BOD_RSTEN = 2;
  localparam int BOD_RSTF = 1;
  localparam int BOD_STATE = 0;
  // Blanking after enable, in slow oscillator cycles
  localparam logic [1:0] BLANK_SLOW_CYCLES = 2'h2;
  localparam logic [2:0] SYNC_ONES = 3'h3;

  typedef enum logic [1:0] {
    RFBO_RST_NONE,
    RFBO_RST_SOFT,
    RFBO_RST_PIN,
    RFBO_RST_FAULT
  } rfbo_cause_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rfbo_sfr_t;

  typedef struct packed {
    logic en;
    logic [2:0] level;
    logic rst_en;
  } rfbo_cfg_t;
endpackage

// ==== core/rfbo_qual.sv ====
// Purpose: Qualify the brown-out comparator output after enable
// Assumes: Comparator and slow oscillator are asynchronous pins
// Notes: Output stays low while disabled or blanked
`timescale 1ns/1ps
module rfbo_qual (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control and raw inputs
  input wire logic enable,
  input wire logic cmp_pin,
  input wire logic slow_osc_pin,
  // Result
  output logic below
);
  logic [1:0] cmp_sync_reg;
  logic [2:0] osc_sync_reg;
  logic [1:0] blank_reg;
  logic [1:0] blank_next;
  logic below_reg;
  wire slow_edge = osc_sync_reg[1] & ~osc_sync_reg[2];
  wire blanked = blank_reg != 2'(rfbo_pkg::BLANK_SLOW_CYCLES + 2'h1);

  // First slow edge may come at once, so one edge more than the blank length
  assign blank_next = !enable ? 2'h0 : (blanked && slow_edge) ? 2'(blank_reg + 2'h1) : blank_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      cmp_sync_reg <= 2'h0;
      osc_sync_reg <= 3'h0;
      blank_reg <= 2'h0;
      below_reg <= 1'b0;
    end else begin
      cmp_sync_reg <= {cmp_sync_reg[0], cmp_pin};
      osc_sync_reg <= {osc_sync_reg[1:0], slow_osc_pin};
      blank_reg <= blank_next; // R12
      below_reg <= enable && !blanked && cmp_sync_reg[1]; // R18
    end
  end
  assign below = below_reg;

  property p_blank_hold;
    @(posedge clk) disable iff (rst) $rose(enable) |=> (!below)[*2];
  endproperty
  a_blank_hold: assert property (p_blank_hold) else $error("Brown-out output valid too early"); // R12
  // Switching off must re-arm the blanking for the next enable
  property p_blank_rearm;
    @(posedge clk) disable iff (rst) !enable |=> blanked;
  endproperty
  a_blank_rearm: assert property (p_blank_rearm) else $error("Blanking not re-armed"); // R12
endmodule // rfbo_qual

// ==== core/rfbo_ctrl.sv ====
// Purpose: Reset-source flags, auxiliary control bits and brown-out control
// Assumes: SFR bus on the system clock; reset causes are one-cycle pulses
// Notes: Flags live outside SYS_RST so they survive the resets they record
//
// Behaviour
// R1 - Software reset sets soft reset flag
// R2 - Reset pin sets pin reset flag
// R3 - Code overrun resets chip, sets fault flag
// R4 - Debug with debug disabled: flag only
// R5 - User flag is plain read/write
// R6 - Swap bit exchanges serial receive/transmit pins
// R7 - Pin swap takes effect immediately
// R8 - Reserved bit reads zero
// R9 - Bit zero selects active data pointer
// R10 - Inactive pointer keeps its contents
// R11 - Enable bit powers brown-out detection
// R12 - Detector output blanked 2-3 slow cycles
// R13 - Level field selects threshold voltage
// R14 - Threshold crossing either way sets flag
// R15 - Request needs flag and both enables
// R16 - Reset-enable bit allows brown-out reset
// R17 - Brown-out reset sets its flag
// R18 - State bit shows below-threshold when enabled
// R19 - Config byte loads controls after reset
// R20 - Flags persist through resets
`timescale 1ns/1ps
module rfbo_ctrl (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic PWR_ON_RST,
  // Register bus
  input wire rfbo_pkg::rfbo_sfr_t SFR_IN,
  output logic [7:0] SFR_RDATA,
  output logic SFR_HIT,
  // Reset causes
  input wire logic SOFT_RESET_REQ,
  input wire logic RESET_PIN_EVENT,
  input wire logic PC_OVERRUN,
  input wire logic ON_CHIP_DEBUG,
  input wire logic DEBUG_ENABLE,
  input wire logic [7:0] CONFIG_BYTE_TWO,
  output logic FAULT_RESET_REQ,
  output logic BROWNOUT_RESET_REQ,
  // Brown-out analog side
  input wire logic BOD_CMP_BELOW,
  input wire logic SLOW_INTERNAL_OSC,
  output logic BROWNOUT_ENABLE,
  output logic [2:0] BROWNOUT_LEVEL_SEL,
  input wire logic BROWNOUT_IRQ_ENABLE,
  input wire logic GLOBAL_IRQ_ENABLE,
  output logic BROWNOUT_IRQ,
  // Serial pins and pointer select
  input wire logic SERIAL0_TX,
  output logic SERIAL0_RX,
  input wire logic P0_6_IN,
  input wire logic P0_7_IN,
  output logic P0_6_OUT,
  output logic P0_7_OUT,
  output logic POINTER_SELECT
);
  logic soft_reg, pin_reg, fault_reg, brst_flag_reg;
  logic user_reg, swap_reg, dps_reg;
  logic en_reg, rsten_reg, irqf_reg;
  logic [2:0] lvl_reg;
  logic below, below_q_reg;
  logic [1:0] pin_sync_reg;
  logic [1:0] p0_meta_reg, p0_sync_reg;

  wire wr_aux = SFR_IN.wr && SFR_IN.addr == rfbo_pkg::ADDR_AUX;
  wire wr_bod = SFR_IN.wr && SFR_IN.addr == rfbo_pkg::ADDR_BOD;
  wire [7:0] wd = SFR_IN.wdata;
  wire pin_event = pin_sync_reg[1];
  wire debug_hold = ON_CHIP_DEBUG && !DEBUG_ENABLE;
  wire bod_reset = rsten_reg && below && !below_q_reg; // R16
  wire crossing = below != below_q_reg; // R14

  rfbo_qual u_qual (
    .clk(CLK),
    .rst(SYS_RST),
    .enable(en_reg),
    .cmp_pin(BOD_CMP_BELOW),
    .slow_osc_pin(SLOW_INTERNAL_OSC),
    .below(below)
  );

  // ****************************************
  // Reset-source flags: power-on reset only
  // ****************************************
  // Set wins over a same-cycle software write
  always_ff @(posedge CLK) begin
    if (PWR_ON_RST) begin
      soft_reg <= 1'b0;
      pin_reg <= 1'b0;
      fault_reg <= 1'b0;
      brst_flag_reg <= 1'b0;
      pin_sync_reg <= 2'h0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[0], RESET_PIN_EVENT};
      soft_reg <= SOFT_RESET_REQ | (wr_aux ? wd[rfbo_pkg::AUX_SOFT] : soft_reg); // R1 R20
      pin_reg <= pin_event | (wr_aux ? wd[rfbo_pkg::AUX_PIN] : pin_reg); // R2 R20
      fault_reg <= PC_OVERRUN | (wr_aux ? wd[rfbo_pkg::AUX_FAULT] : fault_reg); // R3 R4
      brst_flag_reg <= bod_reset | (wr_bod ? wd[rfbo_pkg::BOD_RSTF] : brst_flag_reg); // R17
    end
  end

  assign FAULT_RESET_REQ = PC_OVERRUN && !debug_hold; // R3 R4
  assign BROWNOUT_RESET_REQ = bod_reset; // R16

  // ****************************************
  // Control bits under system reset
  // ****************************************
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      user_reg <= 1'b0;
      swap_reg <= 1'b0;
      dps_reg <= 1'b0; // R9
      irqf_reg <= 1'b0;
      below_q_reg <= 1'b0;
      // Fuse byte is a static level, so it is loaded straight in reset
      en_reg <= CONFIG_BYTE_TWO[rfbo_pkg::BOD_EN]; // R19
      lvl_reg <= CONFIG_BYTE_TWO[rfbo_pkg::BOD_LVL_HI:rfbo_pkg::BOD_LVL_LO]; // R19
      rsten_reg <= CONFIG_BYTE_TWO[rfbo_pkg::BOD_RSTEN]; // R19
    end else begin
      below_q_reg <= below;
      if (wr_aux) begin
        user_reg <= wd[rfbo_pkg::AUX_USER]; // R5
        swap_reg <= wd[rfbo_pkg::AUX_SWAP]; // R7
        dps_reg <= wd[rfbo_pkg::AUX_DPS]; // R9 R10
      end
      irqf_reg <= crossing | (wr_bod ? wd[rfbo_pkg::BOD_IRQF] : irqf_reg); // R14
      if (wr_bod) begin
        en_reg <= wd[rfbo_pkg::BOD_EN]; // R11
        lvl_reg <= wd[rfbo_pkg::BOD_LVL_HI:rfbo_pkg::BOD_LVL_LO]; // R13
        rsten_reg <= wd[rfbo_pkg::BOD_RSTEN];
      end
    end
  end

  // ****************************************
  // Serial receive pin synchronisers
  // ****************************************
  // Both pins resync ahead of the swap mux, so the swap itself stays immediate
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      p0_meta_reg <= 2'h3;
      p0_sync_reg <= 2'h3;
    end else begin
      p0_meta_reg <= {P0_7_IN, P0_6_IN};
      p0_sync_reg <= p0_meta_reg;
    end
  end

  // ****************************************
  // Outputs and read mux
  // ****************************************
  assign BROWNOUT_ENABLE = en_reg;
  assign BROWNOUT_LEVEL_SEL = lvl_reg; // R13
  assign BROWNOUT_IRQ = irqf_reg && BROWNOUT_IRQ_ENABLE && GLOBAL_IRQ_ENABLE; // R15
  assign POINTER_SELECT = dps_reg; // R9
  assign P0_6_OUT = swap_reg ? 1'b1 : SERIAL0_TX; // R6
  assign P0_7_OUT = swap_reg ? SERIAL0_TX : 1'b1; // R6
  assign SERIAL0_RX = swap_reg ? p0_sync_reg[0] : p0_sync_reg[1]; // R6 R7

  wire [7:0] aux_val = {soft_reg, pin_reg, fault_reg, 1'b0, user_reg, swap_reg, 1'b0, dps_reg}; // R8
  wire [7:0] bod_val = {en_reg, lvl_reg, irqf_reg, rsten_reg, brst_flag_reg, below}; // R18
  assign SFR_RDATA = (SFR_IN.addr == rfbo_pkg::ADDR_AUX) ? aux_val :
                     (SFR_IN.addr == rfbo_pkg::ADDR_BOD) ? bod_val : 8'h00;
  assign SFR_HIT = SFR_IN.addr == rfbo_pkg::ADDR_AUX || SFR_IN.addr == rfbo_pkg::ADDR_BOD;

  // ****************************************
  // Checks
  // ****************************************
  property p_soft_set;
    @(posedge CLK) disable iff (PWR_ON_RST) SOFT_RESET_REQ |=> soft_reg;
  endproperty
  a_soft_set: assert property (p_soft_set) else $error("Soft flag not set"); // R1
  property p_fault_set;
    @(posedge CLK) disable iff (PWR_ON_RST) PC_OVERRUN |=> fault_reg;
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("Fault flag not set"); // R3
  property p_debug_hold;
    @(posedge CLK) debug_hold |-> !FAULT_RESET_REQ;
  endproperty
  a_debug_hold: assert property (p_debug_hold) else $error("Fault reset in debug"); // R4
  property p_rsvd;
    @(posedge CLK) SFR_IN.addr == rfbo_pkg::ADDR_AUX |-> SFR_RDATA[rfbo_pkg::AUX_RSVD] == 1'b0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("Reserved bit nonzero"); // R8
  property p_state_off;
    @(posedge CLK) disable iff (SYS_RST) !en_reg |=> !below;
  endproperty
  a_state_off: assert property (p_state_off) else $error("State set while disabled"); // R18
  property p_cross;
    @(posedge CLK) disable iff (SYS_RST) $changed(below) |=> irqf_reg;
  endproperty
  a_cross: assert property (p_cross) else $error("Crossing missed"); // R14
  property p_irq;
    @(posedge CLK) BROWNOUT_IRQ |-> irqf_reg && GLOBAL_IRQ_ENABLE;
  endproperty
  a_irq: assert property (p_irq) else $error("Spurious request"); // R15
  property p_bod_rst;
    @(posedge CLK) disable iff (SYS_RST) BROWNOUT_RESET_REQ |-> rsten_reg ##1 brst_flag_reg;
  endproperty
  a_bod_rst: assert property (p_bod_rst) else $error("Brown-out reset flag"); // R16
  property p_dps;
    @(posedge CLK) disable iff (SYS_RST) wr_aux |=> POINTER_SELECT == $past(wd[rfbo_pkg::AUX_DPS]);
  endproperty
  a_dps: assert property (p_dps) else $error("Pointer select wrong"); // R9
  property p_pin_set;
    @(posedge CLK) disable iff (PWR_ON_RST) pin_event |=> pin_reg;
  endproperty
  a_pin_set: assert property (p_pin_set) else $error("Pin flag not set"); // R2
  property p_user;
    @(posedge CLK) disable iff (SYS_RST) wr_aux |=> user_reg == $past(wd[rfbo_pkg::AUX_USER]);
  endproperty
  a_user: assert property (p_user) else $error("User flag wrong"); // R5
  property p_swap;
    @(posedge CLK) swap_reg |-> P0_7_OUT == SERIAL0_TX && P0_6_OUT == 1'b1;
  endproperty
  a_swap: assert property (p_swap) else $error("Transmit not on swapped pin"); // R6
  property p_en_wr;
    @(posedge CLK) disable iff (SYS_RST) wr_bod |=> BROWNOUT_ENABLE == $past(wd[rfbo_pkg::BOD_EN]);
  endproperty
  a_en_wr: assert property (p_en_wr) else $error("Enable not written"); // R11
  property p_lvl_wr;
    @(posedge CLK) disable iff (SYS_RST)
      wr_bod |=> BROWNOUT_LEVEL_SEL == $past(wd[rfbo_pkg::BOD_LVL_HI:rfbo_pkg::BOD_LVL_LO]);
  endproperty
  a_lvl_wr: assert property (p_lvl_wr) else $error("Level not written"); // R13
  property p_brst_set;
    @(posedge CLK) disable iff (PWR_ON_RST) bod_reset |=> brst_flag_reg;
  endproperty
  a_brst_set: assert property (p_brst_set) else $error("Brown-out reset flag not set"); // R17
  property p_cfg_load;
    @(posedge CLK) SYS_RST |=> {en_reg, lvl_reg, rsten_reg} == $past({CONFIG_BYTE_TWO[rfbo_pkg::BOD_EN],
      CONFIG_BYTE_TWO[rfbo_pkg::BOD_LVL_HI:rfbo_pkg::BOD_LVL_LO], CONFIG_BYTE_TWO[rfbo_pkg::BOD_RSTEN]});
  endproperty
  a_cfg_load: assert property (p_cfg_load) else $error("Config byte not loaded"); // R19
  property p_flags_keep;
    @(posedge CLK) disable iff (PWR_ON_RST) SYS_RST && !SOFT_RESET_REQ && !wr_aux |=> soft_reg == $past(soft_reg);
  endproperty
  a_flags_keep: assert property (p_flags_keep) else $error("Flag lost in reset"); // R20
  c_swap: cover property (@(posedge CLK) $rose(swap_reg));
  c_bod_rst: cover property (@(posedge CLK) BROWNOUT_RESET_REQ);
  c_irq: cover property (@(posedge CLK) $rose(BROWNOUT_IRQ));
  c_set_race: cover property (@(posedge CLK) SOFT_RESET_REQ && wr_aux);
endmodule // rfbo_ctrl

// ==== tb/reset_flags_brownout_ctrl_tb.sv ====
// Purpose: Self-checking bench for the reset-flag and brown-out control block
// Assumes: Register bus reads are combinational, writes land at the strobe edge
// Notes: Slow oscillator is a divided system clock so blanking ends quickly
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %0t got %h expected %h", $time, (g), (e)); end end
module reset_flags_brownout_ctrl_tb;
  // ************************************************
  // Stimulus and observed signals
  // ************************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] mask;
    logic [7:0] exp;
    logic hit;
  } rfbo_tb_row_t;
  logic CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic PWR_ON_RST = 1'b1;
  rfbo_pkg::rfbo_sfr_t SFR_IN = '0;
  logic SOFT_RESET_REQ = 1'b0, RESET_PIN_EVENT = 1'b0, PC_OVERRUN = 1'b0;
  logic ON_CHIP_DEBUG = 1'b0, DEBUG_ENABLE = 1'b0, BOD_CMP_BELOW = 1'b0;
  logic BROWNOUT_IRQ_ENABLE = 1'b0, GLOBAL_IRQ_ENABLE = 1'b0, SERIAL0_TX = 1'b0;
  logic P0_6_IN = 1'b0, P0_7_IN = 1'b1;
  logic [7:0] CONFIG_BYTE_TWO = 8'h00;
  logic [7:0] SFR_RDATA;
  logic SFR_HIT, FAULT_RESET_REQ, BROWNOUT_RESET_REQ, BROWNOUT_ENABLE, BROWNOUT_IRQ;
  logic [2:0] BROWNOUT_LEVEL_SEL;
  logic SERIAL0_RX, P0_6_OUT, P0_7_OUT, POINTER_SELECT;
  logic [2:0] div = 3'h0;
  logic [7:0] rv;
  int bad_count = 0, checks = 0, bor_cnt = 0;
  // Bit 4 of the auxiliary register is unimplemented, so it is masked off
  rfbo_tb_row_t rows [5] = '{'{8'ha2, 8'h0d, 8'hef, 8'h0d, 1'b1}, '{8'ha2, 8'h02, 8'hef, 8'h00, 1'b1},
    '{8'ha3, 8'h74, 8'hff, 8'h74, 1'b1}, '{8'ha3, 8'h01, 8'hff, 8'h00, 1'b1}, '{8'ha4, 8'hff, 8'hff, 8'h00, 1'b0}};

  always #10 CLK = ~CLK;
  always @(posedge CLK) div <= div + 3'h1;
  always @(posedge CLK) if (BROWNOUT_RESET_REQ === 1'b1) bor_cnt <= bor_cnt + 1;

  rfbo_ctrl uut (.CLK(CLK), .SYS_RST(SYS_RST), .PWR_ON_RST(PWR_ON_RST), .SFR_IN(SFR_IN),
    .SFR_RDATA(SFR_RDATA), .SFR_HIT(SFR_HIT), .SOFT_RESET_REQ(SOFT_RESET_REQ),
    .RESET_PIN_EVENT(RESET_PIN_EVENT), .PC_OVERRUN(PC_OVERRUN), .ON_CHIP_DEBUG(ON_CHIP_DEBUG),
    .DEBUG_ENABLE(DEBUG_ENABLE), .CONFIG_BYTE_TWO(CONFIG_BYTE_TWO), .FAULT_RESET_REQ(FAULT_RESET_REQ),
    .BROWNOUT_RESET_REQ(BROWNOUT_RESET_REQ), .BOD_CMP_BELOW(BOD_CMP_BELOW), .SLOW_INTERNAL_OSC(div[2]),
    .BROWNOUT_ENABLE(BROWNOUT_ENABLE), .BROWNOUT_LEVEL_SEL(BROWNOUT_LEVEL_SEL),
    .BROWNOUT_IRQ_ENABLE(BROWNOUT_IRQ_ENABLE), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE),
    .BROWNOUT_IRQ(BROWNOUT_IRQ), .SERIAL0_TX(SERIAL0_TX), .SERIAL0_RX(SERIAL0_RX), .P0_6_IN(P0_6_IN),
    .P0_7_IN(P0_7_IN), .P0_6_OUT(P0_6_OUT), .P0_7_OUT(P0_7_OUT), .POINTER_SELECT(POINTER_SELECT));

  // ************************************************
  // Bus tasks and closing
  // ************************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK) SFR_IN <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge CLK) SFR_IN <= '0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge CLK) SFR_IN <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge CLK) rv = SFR_RDATA;
  endtask
  task automatic stop_test();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #40000;
    bad_count++;
    stop_test();
  end

  // ************************************************
  // Main sequence
  // ************************************************
  initial begin
    repeat (2) @(posedge CLK);
    SYS_RST <= 1'b0;
    PWR_ON_RST <= 1'b0;
    @(posedge CLK);
    rd(8'ha2); `CHK(rv & 8'hef, 8'h00)
    rd(8'ha3); `CHK(rv, 8'h00)
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr); `CHK(rv & rows[i].mask, rows[i].exp)
      `CHK(SFR_HIT, rows[i].hit)
    end
    for (int i = 0; i < 4; i++) begin
      wr(8'ha3, {1'b0, 3'(i), 4'h0}); `CHK(BROWNOUT_LEVEL_SEL, 3'(i))
    end
    // Transmit held low so the idle level of the unused pin shows
    wr(8'ha2, 8'h00);
    `CHK({SERIAL0_RX, P0_6_OUT, P0_7_OUT, POINTER_SELECT}, 4'b1010)
    wr(8'ha2, 8'h05);
    `CHK({SERIAL0_RX, P0_6_OUT, P0_7_OUT, POINTER_SELECT}, 4'b0101)
    @(posedge CLK) SERIAL0_TX <= 1'b1;
    #1 `CHK({P0_6_OUT, P0_7_OUT}, 2'b11)
    // Fuse byte changes so the mid-run reset shows a non-zero load
    @(posedge CLK) begin
      SOFT_RESET_REQ <= 1'b1;
      CONFIG_BYTE_TWO <= 8'ha4;
    end
    @(posedge CLK) SOFT_RESET_REQ <= 1'b0;
    @(posedge CLK) SYS_RST <= 1'b1;
    @(posedge CLK) SYS_RST <= 1'b0;
    @(posedge CLK);
    rd(8'ha2); `CHK({rv[7], rv[2], rv[0]}, 3'b100)
    rd(8'ha3); `CHK(rv, 8'ha4)
    wr(8'ha3, 8'h00);
    @(posedge CLK) begin
      ON_CHIP_DEBUG <= 1'b1;
      PC_OVERRUN <= 1'b1;
    end
    #1 `CHK(FAULT_RESET_REQ, 1'b0)
    @(posedge CLK) PC_OVERRUN <= 1'b0;
    rd(8'ha2); `CHK(rv[5], 1'b1)
    wr(8'ha2, 8'h00);
    rd(8'ha2); `CHK(rv & 8'he0, 8'h00)
    @(posedge CLK) begin
      ON_CHIP_DEBUG <= 1'b0;
      PC_OVERRUN <= 1'b1;
    end
    #1 `CHK(FAULT_RESET_REQ, 1'b1)
    @(posedge CLK) begin
      PC_OVERRUN <= 1'b0;
      RESET_PIN_EVENT <= 1'b1;
    end
    repeat (3) @(posedge CLK);
    RESET_PIN_EVENT <= 1'b0;
    repeat (4) @(posedge CLK);
    rd(8'ha2); `CHK(rv[6:5], 2'b11)
    // Hardware set and software clear in one cycle: the set must win
    @(posedge CLK) begin
      SFR_IN <= '{wr: 1'b1, rd: 1'b0, addr: 8'ha2, wdata: 8'h00};
      SOFT_RESET_REQ <= 1'b1;
    end
    @(posedge CLK) begin
      SFR_IN <= '0;
      SOFT_RESET_REQ <= 1'b0;
    end
    rd(8'ha2); `CHK(rv[7:5], 3'b100)
    // Comparator already low-going before enable: blanking must hide it
    @(posedge CLK) BOD_CMP_BELOW <= 1'b1;
    wr(8'ha3, 8'h84); `CHK(BROWNOUT_ENABLE, 1'b1)
    repeat (2) @(posedge CLK);
    rd(8'ha3); `CHK(rv[0], 1'b0)
    repeat (60) @(posedge CLK);
    rd(8'ha3); `CHK(rv[3:0], 4'b1111)
    `CHK(bor_cnt != 0, 1'b1)
    @(posedge CLK) BROWNOUT_IRQ_ENABLE <= 1'b1;
    #1 `CHK(BROWNOUT_IRQ, 1'b0)
    @(posedge CLK) GLOBAL_IRQ_ENABLE <= 1'b1;
    #1 `CHK(BROWNOUT_IRQ, 1'b1)
    wr(8'ha3, 8'h80);
    rd(8'ha3); `CHK(rv[3], 1'b0)
    `CHK(BROWNOUT_IRQ, 1'b0)
    @(posedge CLK) BOD_CMP_BELOW <= 1'b0;
    repeat (20) @(posedge CLK);
    rd(8'ha3); `CHK({rv[3], rv[0]}, 2'b10)
    wr(8'ha3, 8'h00);
    @(posedge CLK) BOD_CMP_BELOW <= 1'b1;
    repeat (20) @(posedge CLK);
    rd(8'ha3); `CHK({BROWNOUT_ENABLE, rv[0]}, 2'b00)
    stop_test();
  end
endmodule // reset_flags_brownout_ctrl_tb
